/* design/tipc_top.sv */
// four-channel input pulse interval capture timer with axi4-lite registers
//
// Overview of operation
// - start trigger makes counter count up from zero each count clock.
// - valid input edge captures count, clears counter, raises channel interrupt.
// - each capture sets overflow flag if counter wrapped, else clears it.
// - several wraps in one period still give overflow flag one.
// - start trigger while running captures with clear and interrupt.
// - input sampled on selected operating clock, one cycle uncertainty.
// - route bit one feeds serial receive input into channel one.
// - unit clock enable zero blocks register reads and writes, except to the control register.
// - four independent channels numbered zero to three.
// - start interrupt option raises interrupt when counter cleared at start.
// - stop trigger clears enable, freezes counter, keeps overflow flag.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module tipc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] timer_input_pin,
  input wire logic serial_receive_input,
  output logic irq
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic unit_en;
    logic input_route;
    logic [7:0] presc0;
    logic [7:0] presc1;
    logic [7:0] div0;
    logic [7:0] div1;
    logic tick0;
    logic tick1;
    logic [3:0] start;
    logic [3:0] stop;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    tipc_pkg::tipc_mode_s [3:0] mode;
  } tipc_st_s;

  tipc_st_s s_q;
  tipc_st_s s_d;
  tipc_pkg::tipc_ch_in_s [3:0] ch_in;
  tipc_pkg::tipc_ch_out_s [3:0] ch_out;
  logic [3:0] raw_pin;
  logic [3:0] ch_irq;
  logic do_write;
  logic do_read;

  // tests whether a register offset is a word-aligned channel slot within a bank of four
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    byte_merge = r;
  endfunction

  // mode register word: edge, clock select, start select, start irq, out mode
  function automatic logic [31:0] mode_word(input tipc_pkg::tipc_mode_s m);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tipc_pkg::MODE_EDGE_LSB +: 2] = m.edge_sel;
    w[tipc_pkg::MODE_CKS_BIT] = m.clk_sel;
    w[tipc_pkg::MODE_STS_LSB +: 3] = m.start_sel;
    w[tipc_pkg::MODE_MD0_BIT] = m.start_irq;
    w[tipc_pkg::MODE_OM_BIT] = m.out_mode;
    mode_word = w;
  endfunction

  function automatic tipc_pkg::tipc_mode_s word_mode(input logic [31:0] w);
    tipc_pkg::tipc_mode_s m;
    m.edge_sel = tipc_pkg::tipc_edge_e'(w[tipc_pkg::MODE_EDGE_LSB +: 2]);
    m.clk_sel = w[tipc_pkg::MODE_CKS_BIT];
    m.start_sel = w[tipc_pkg::MODE_STS_LSB +: 3];
    m.start_irq = w[tipc_pkg::MODE_MD0_BIT];
    m.out_mode = w[tipc_pkg::MODE_OM_BIT];
    word_mode = m;
  endfunction

  // any register of the map; write-only triggers and read-only views answer okay
  function automatic logic known_reg(input logic [7:0] a);
    logic k;
    k = (a == tipc_pkg::OFS_CTRL) || (a == tipc_pkg::OFS_START);
    k = k || (a == tipc_pkg::OFS_STOP) || (a == tipc_pkg::OFS_ENSTAT);
    k = k || (a == tipc_pkg::OFS_ISC) || (a == tipc_pkg::OFS_PRESC);
    k = k || (a == tipc_pkg::OFS_IRQ_STAT) || (a == tipc_pkg::OFS_IRQ_MASK);
    k = k || in_bank(a, tipc_pkg::OFS_MODE0) || in_bank(a, tipc_pkg::OFS_CNT0);
    k = k || in_bank(a, tipc_pkg::OFS_DATA0) || in_bank(a, tipc_pkg::OFS_STAT0);
    known_reg = k;
  endfunction

  always_comb begin
    raw_pin = timer_input_pin;
    if (s_q.input_route) begin
      raw_pin[tipc_pkg::ROUTE_CH] = serial_receive_input;
    end
  end

  for (genvar n = 0; n < tipc_pkg::NCH; n++) begin : g_ch
    assign ch_in[n].start = s_q.start[n];
    assign ch_in[n].stop = s_q.stop[n];
    assign ch_in[n].edge_sel = s_q.mode[n].edge_sel;
    assign ch_in[n].clk_sel = s_q.mode[n].clk_sel;
    assign ch_in[n].start_irq = s_q.mode[n].start_irq;
    assign ch_in[n].tick0 = s_q.tick0;
    assign ch_in[n].tick1 = s_q.tick1;
    // the channel carries its own three-stage synchroniser
    assign ch_in[n].pin = raw_pin[n];
    assign ch_irq[n] = ch_out[n].irq;
    tipc_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .ci(ch_in[n]),
      .co(ch_out[n])
    );
  end

  assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    logic [31:0] rd;
    logic [1:0] idx;
    logic ok;
    logic [31:0] mw;
    tipc_pkg::tipc_mode_s nm;
    rd = 32'h0000_0000;
    idx = 2'h0;
    ok = 1'b1;
    mw = 32'h0000_0000;
    nm = '0;
    s_d = s_q;
    s_d.start = 4'h0;
    s_d.stop = 4'h0;
    // operating clock enables from prescalers
    s_d.tick0 = (s_q.div0 == s_q.presc0);
    s_d.tick1 = (s_q.div1 == s_q.presc1);
    s_d.div0 = s_d.tick0 ? 8'h00 : s_q.div0 + 8'h01;
    s_d.div1 = s_d.tick1 ? 8'h00 : s_q.div1 + 8'h01;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      idx = s_q.awaddr[3:2];
      ok = 1'b1;
      if (s_q.awaddr == tipc_pkg::OFS_CTRL) begin
        if (s_q.wstrb[0]) begin
          s_d.unit_en = s_q.wdata[tipc_pkg::CTRL_EN_BIT];
        end
      end else if (!s_q.unit_en) begin
        ok = 1'b1;
      end else if (s_q.awaddr == tipc_pkg::OFS_START) begin
        s_d.start = s_q.wstrb[0] ? s_q.wdata[3:0] : 4'h0;
      end else if (s_q.awaddr == tipc_pkg::OFS_STOP) begin
        s_d.stop = s_q.wstrb[0] ? s_q.wdata[3:0] : 4'h0;
      end else if (s_q.awaddr == tipc_pkg::OFS_ISC) begin
        if (s_q.wstrb[0]) begin
          s_d.input_route = s_q.wdata[tipc_pkg::ISC_ROUTE_BIT];
        end
      end else if (s_q.awaddr == tipc_pkg::OFS_PRESC) begin
        mw = byte_merge({16'h0, s_q.presc1, s_q.presc0}, s_q.wdata, s_q.wstrb);
        s_d.presc0 = mw[7:0];
        s_d.presc1 = mw[15:8];
      end else if (s_q.awaddr == tipc_pkg::OFS_IRQ_MASK) begin
        if (s_q.wstrb[0]) begin
          s_d.irq_mask = s_q.wdata[3:0];
        end
      end else if (in_bank(s_q.awaddr, tipc_pkg::OFS_MODE0)) begin
        // only the edge select changes while running
        mw = byte_merge(mode_word(s_q.mode[idx]), s_q.wdata, s_q.wstrb);
        nm = word_mode(mw);
        if (ch_out[idx].enabled) begin
          s_d.mode[idx].edge_sel = nm.edge_sel;
        end else begin
          s_d.mode[idx] = nm;
        end
      end else if (!known_reg(s_q.awaddr)) begin
        ok = 1'b0;
      end
      s_d.bresp = ok ? tipc_pkg::RESP_OKAY : tipc_pkg::RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // sticky interrupt status; hardware set wins over read clear
    if (do_read) begin
      idx = s_axi_araddr[3:2];
      ok = 1'b1;
      if (s_axi_araddr == tipc_pkg::OFS_CTRL) begin
        rd = {31'h0, s_q.unit_en};
      end else if (!s_q.unit_en) begin
        rd = 32'h0000_0000;
      end else if (s_axi_araddr == tipc_pkg::OFS_ENSTAT) begin
        for (int n = 0; n < tipc_pkg::NCH; n++) begin
          rd[n] = ch_out[n].enabled;
        end
      end else if (s_axi_araddr == tipc_pkg::OFS_ISC) begin
        rd = {30'h0, s_q.input_route, 1'b0};
      end else if (s_axi_araddr == tipc_pkg::OFS_PRESC) begin
        rd = {16'h0, s_q.presc1, s_q.presc0};
      end else if (s_axi_araddr == tipc_pkg::OFS_IRQ_STAT) begin
        rd = {28'h0, s_q.irq_stat};
        s_d.irq_stat = 4'h0;
      end else if (s_axi_araddr == tipc_pkg::OFS_IRQ_MASK) begin
        rd = {28'h0, s_q.irq_mask};
      end else if (in_bank(s_axi_araddr, tipc_pkg::OFS_MODE0)) begin
        rd = mode_word(s_q.mode[idx]);
      end else if (in_bank(s_axi_araddr, tipc_pkg::OFS_CNT0)) begin
        rd = {16'h0, ch_out[idx].count};
      end else if (in_bank(s_axi_araddr, tipc_pkg::OFS_DATA0)) begin
        rd = {16'h0, ch_out[idx].data};
      end else if (in_bank(s_axi_araddr, tipc_pkg::OFS_STAT0)) begin
        rd = {31'h0, ch_out[idx].ovf};
      end else if (!known_reg(s_axi_araddr)) begin
        ok = 1'b0;
      end
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = ok ? tipc_pkg::RESP_OKAY : tipc_pkg::RESP_SLVERR;
    end
    s_d.irq_stat = s_d.irq_stat | ch_irq;
    // clearing the unit enable resets the registers and stops all channels; channel counts, data and overflow flags keep their values
    if (!s_q.unit_en) begin
      s_d.input_route = 1'b0;
      s_d.irq_stat = 4'h0;
      s_d.irq_mask = 4'h0;
      s_d.presc0 = tipc_pkg::PRESC_RST;
      s_d.presc1 = tipc_pkg::PRESC_RST;
      s_d.mode = '0;
      s_d.stop = 4'hF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // no new write is taken while its response still stands
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);
endmodule

/* design/tipc_pkg.sv */
// package for the four-channel input pulse interval capture timer
package tipc_pkg;
  localparam int NCH = 4;
  localparam int CW = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_STOP = 8'h08;
  localparam logic [7:0] OFS_ENSTAT = 8'h0C;
  localparam logic [7:0] OFS_ISC = 8'h10;
  localparam logic [7:0] OFS_PRESC = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_MODE0 = 8'h20;
  localparam logic [7:0] OFS_CNT0 = 8'h30;
  localparam logic [7:0] OFS_DATA0 = 8'h40;
  localparam logic [7:0] OFS_STAT0 = 8'h50;
  // mode register field positions
  localparam int MODE_EDGE_LSB = 0;
  localparam int MODE_CKS_BIT = 2;
  localparam int MODE_STS_LSB = 4;
  localparam int MODE_MD0_BIT = 8;
  localparam int MODE_OM_BIT = 9;
  localparam int STAT_OVF_BIT = 0;
  localparam int ISC_ROUTE_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam int ROUTE_CH = 1;
  localparam logic [2:0] STS_EDGE = 3'h1;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] CNT_FULL = 16'hFFFF;
  localparam logic [9:0] MODE_RST = 10'h000;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TIPC_EDGE_FALL = 2'b00,
    TIPC_EDGE_RISE = 2'b01,
    TIPC_EDGE_BOTH = 2'b10,
    TIPC_EDGE_BOTH2 = 2'b11
  } tipc_edge_e;

  typedef struct packed {
    tipc_edge_e edge_sel;
    logic clk_sel;
    logic [2:0] start_sel;
    logic start_irq;
    logic out_mode;
  } tipc_mode_s;

  typedef struct packed {
    logic start;
    logic stop;
    tipc_edge_e edge_sel;
    logic clk_sel;
    logic start_irq;
    logic tick0;
    logic tick1;
    logic pin;
  } tipc_ch_in_s;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] data;
    logic ovf;
    logic enabled;
    logic irq;
  } tipc_ch_out_s;
endpackage

/* design/tipc_channel.sv */
// one capture channel: pin sampler, edge detect, up counter and capture
`timescale 1ns/10ps
module tipc_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tipc_pkg::tipc_ch_in_s ci,
  output tipc_pkg::tipc_ch_out_s co
);
  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic edge_seen;
    logic armed;
    logic wrapped;
    logic [tipc_pkg::CW-1:0] count;
    logic [tipc_pkg::CW-1:0] data;
    logic ovf;
    logic enabled;
    logic irq;
  } tipc_chst_s;

  tipc_chst_s s_q;
  tipc_chst_s s_d;
  logic tick;
  logic stable;
  logic rise;
  logic fall;
  logic valid_edge;

  assign tick = ci.clk_sel ? ci.tick1 : ci.tick0;
  assign stable = (s_q.sync[1] == s_q.sync[2]);
  assign rise = stable && s_q.sync[2] && !s_q.level;
  assign fall = stable && !s_q.sync[2] && s_q.level;

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.sync = {s_q.sync[1:0], ci.pin};
    if (stable) begin
      s_d.level = s_q.sync[2];
    end
    case (ci.edge_sel)
      tipc_pkg::TIPC_EDGE_FALL: valid_edge = fall;
      tipc_pkg::TIPC_EDGE_RISE: valid_edge = rise;
      default: valid_edge = rise || fall;
    endcase
    // edges wait for the next operating clock tick; uncertainty is one tick
    if (valid_edge && s_q.enabled) begin
      s_d.edge_seen = 1'b1;
    end
    if (ci.stop) begin
      s_d.enabled = 1'b0;
      s_d.armed = 1'b0;
      s_d.edge_seen = 1'b0;
    end else if (ci.start && !s_q.enabled) begin
      // start arms a clear on next tick
      s_d.enabled = 1'b1;
      s_d.armed = 1'b1;
      s_d.edge_seen = 1'b0;
    end else if (s_q.enabled && tick) begin
      if (s_q.armed) begin
        s_d.armed = 1'b0;
        s_d.count = tipc_pkg::CNT_RST;
        s_d.wrapped = 1'b0;
        s_d.irq = ci.start_irq;
      end else if (s_q.edge_seen || (ci.start && !valid_edge)) begin
        s_d.data = s_q.count;
        s_d.count = tipc_pkg::CNT_RST;
        s_d.irq = 1'b1;
        s_d.edge_seen = 1'b0;
        s_d.ovf = s_q.wrapped;
        s_d.wrapped = 1'b0;
      end else begin
        s_d.count = s_q.count + 16'h0001;
        if (s_q.count == tipc_pkg::CNT_FULL) begin
          s_d.wrapped = 1'b1;
        end
      end
    end else if (ci.start && s_q.enabled) begin
      // start while running captures at the next tick
      s_d.edge_seen = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign co.count = s_q.count;
  assign co.data = s_q.data;
  assign co.ovf = s_q.ovf;
  assign co.enabled = s_q.enabled;
  assign co.irq = s_q.irq;
endmodule

/* sim/tipc_monitor.sv */
// bus handshake checker bound to the capture timer top
`timescale 1ns/10ps
module tipc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] timer_input_pin,
  input wire logic serial_receive_input,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_aw_take;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_take: assert property (p_aw_take) else $error("awready high after address taken");
  property p_w_take;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
  endproperty
  a_w_take: assert property (p_w_take) else $error("wready high after data taken");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("bvalid stuck after handshake");
  property p_bv_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_bv_block: assert property (p_bv_block) else $error("address accepted before response");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("rvalid stuck after handshake");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted while data pending");
endmodule

bind tipc_top tipc_monitor u_mon (.*);

/* sim/tipc_pulse_src.sv */
// pulse source standing in for the timer input pins and the serial line
`timescale 1ns/10ps
module tipc_pulse_src (
  input wire logic aclk,
  output logic [3:0] timer_input_pin,
  output logic serial_receive_input
);
  // serial line idles high like a real receiver line
  initial begin
    timer_input_pin = 4'h0;
    serial_receive_input = 1'b1;
  end
  // gap counts from the first edge; called just after a rising clock edge
  task automatic pulse(input int ch, input int gap, input bit both);
    timer_input_pin[ch] <= 1'b1;
    repeat (both ? gap : 4) @(posedge aclk);
    timer_input_pin[ch] <= 1'b0;
    if (!both) begin
      repeat (gap - 4) @(posedge aclk);
      timer_input_pin[ch] <= 1'b1;
      repeat (4) @(posedge aclk);
      timer_input_pin[ch] <= 1'b0;
    end
  endtask
  task automatic rx_low(input int n);
    serial_receive_input <= 1'b0;
    repeat (n) @(posedge aclk);
    serial_receive_input <= 1'b1;
  endtask
endmodule

/* sim/tb_tipc_top.sv */
// self-checking bench: register bus tasks and pulse interval scenarios
`timescale 1ns/10ps
module tb_tipc_top;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [3:0] timer_input_pin;
  logic serial_receive_input;
  logic irq;
  logic [31:0] rd;
  logic [1:0] rr;
  int failures;
  int n_tests;
  int cyc = 0;

  tipc_top DUT (.*);
  tipc_pulse_src src (.aclk(aclk), .timer_input_pin(timer_input_pin),
    .serial_receive_input(serial_receive_input));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard: the overflow case alone takes about 66000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bready and rready stay high for the whole run
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, exp);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axw(tipc_pkg::OFS_MODE0, 32'h11);
    axw(tipc_pkg::OFS_CTRL, 32'h1);
    rdc(tipc_pkg::OFS_MODE0, 32'h0);
    axr(8'hFC, rd, rr);
    chk({30'h0, rr}, {30'h0, tipc_pkg::RESP_SLVERR});
    axw(8'hF8, 32'h0);
    chk({30'h0, rr}, {30'h0, tipc_pkg::RESP_SLVERR});
    axw(tipc_pkg::OFS_IRQ_MASK, 32'hF);
    axw(tipc_pkg::OFS_PRESC, 32'h0);
    // rising edge, edge triggering, master output mode
    axw(tipc_pkg::OFS_MODE0, 32'h11);
    axw(tipc_pkg::OFS_START, 32'h1);
    rdc(tipc_pkg::OFS_ENSTAT, 32'h1);
    src.pulse(0, 20, 0);
    repeat (10) @(posedge aclk);
    rdc(tipc_pkg::OFS_DATA0, 32'h13);
    rdc(tipc_pkg::OFS_STAT0, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    src.pulse(0, 65566, 0);
    repeat (10) @(posedge aclk);
    rdc(tipc_pkg::OFS_DATA0, 32'h1D);
    rdc(tipc_pkg::OFS_STAT0, 32'h1);
    axw(tipc_pkg::OFS_STOP, 32'h1);
    axr(tipc_pkg::OFS_CNT0, rd, rr);
    repeat (5) @(posedge aclk);
    rdc(tipc_pkg::OFS_CNT0, rd);
    rdc(tipc_pkg::OFS_STAT0, 32'h1);
    rdc(tipc_pkg::OFS_ENSTAT, 32'h0);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h1);
    axw(tipc_pkg::OFS_START, 32'h1);
    repeat (20) @(posedge aclk);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h0);
    axw(tipc_pkg::OFS_START, 32'h1);
    repeat (4) @(posedge aclk);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h1);
    rdc(tipc_pkg::OFS_STAT0, 32'h0);
    // restart with the start interrupt option set
    axw(tipc_pkg::OFS_STOP, 32'h1);
    axw(tipc_pkg::OFS_MODE0, 32'h111);
    axw(tipc_pkg::OFS_START, 32'h1);
    repeat (4) @(posedge aclk);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h1);
    // serial line replaces pin 1; pin pulses must be ignored
    axw(tipc_pkg::OFS_IRQ_MASK, 32'h0);
    axw(tipc_pkg::OFS_ISC, 32'h2);
    axw(tipc_pkg::OFS_MODE0 + 8'h04, 32'h10);
    axw(tipc_pkg::OFS_START, 32'h2);
    src.pulse(1, 8, 0);
    src.rx_low(10);
    repeat (10) @(posedge aclk);
    src.rx_low(10);
    repeat (20) @(posedge aclk);
    rdc(tipc_pkg::OFS_DATA0 + 8'h04, 32'h13);
    chk({31'h0, irq}, 32'h0);
    rdc(tipc_pkg::OFS_IRQ_STAT, 32'h2);
    for (int ch = 2; ch < 4; ch++) begin
      axw(tipc_pkg::OFS_MODE0 + 8'(4 * ch), 32'h10 | ch);
      axw(tipc_pkg::OFS_START, 32'h1 << ch);
      src.pulse(ch, 15, 1);
      repeat (10) @(posedge aclk);
      rdc(tipc_pkg::OFS_DATA0 + 8'(4 * ch), 32'h0E);
    end
    // second operating clock at half rate; a 16-cycle gap is eight ticks
    axw(tipc_pkg::OFS_PRESC, 32'h100);
    axw(tipc_pkg::OFS_STOP, 32'h8);
    axw(tipc_pkg::OFS_MODE0 + 8'h0C, 32'h16);
    axw(tipc_pkg::OFS_START, 32'h8);
    src.pulse(3, 16, 1);
    repeat (10) @(posedge aclk);
    rdc(tipc_pkg::OFS_DATA0 + 8'h0C, 32'h07);
    give_verdict();
  end
endmodule
